// [rtl/icdt_pkg.sv]
// constants and types shared by the instruction decode and cycle timing logic
package icdt_pkg;

  localparam int unsigned WORD_W    = 14;
  localparam int unsigned FADDR_W   = 7;
  localparam int unsigned LIT_W     = 11;

  // oscillator clocks per instruction cycle and phase positions
  localparam int unsigned Q_PER_CYC = 4;
  localparam logic [1:0]  Q_FIRST   = 2'h0;
  localparam logic [1:0]  Q_READ    = 2'h1;
  localparam logic [1:0]  Q_PRE_WR  = 2'h2;
  localparam logic [1:0]  Q_LAST    = 2'h3;

  // value held in the instruction register after reset (no-operation)
  localparam logic [13:0] WORD_RST  = 14'h0000;

  // top-level opcode groups, bits 13:12
  localparam logic [1:0]  GRP_BYTE  = 2'h0;
  localparam logic [1:0]  GRP_BIT   = 2'h1;
  localparam logic [1:0]  GRP_FLOW  = 2'h2;
  localparam logic [1:0]  GRP_LIT   = 2'h3;

  // low bits (6:0, 6:3 or 6:5) of the control words with bits 11:7 all zero
  localparam logic [6:0]  OP_NOP    = 7'h00;
  localparam logic [6:0]  OP_RETURN = 7'h08;
  localparam logic [6:0]  OP_RET_INT     = 7'h09;
  localparam logic [6:0]  OP_CALL_WREG   = 7'h0A;
  localparam logic [6:0]  OP_BRANCH_WREG = 7'h0B;
  localparam logic [3:0]  OP_MOVIW  = 4'h2;
  localparam logic [3:0]  OP_MOVWI  = 4'h3;
  localparam logic [1:0]  OP_MOVLB  = 2'h1;

  // bits 11:8 of byte and literal-group words
  localparam logic [3:0]  OP_MOVWF  = 4'h0;
  localparam logic [3:0]  OP_CLR    = 4'h1;
  localparam logic [3:0]  OP_DEC_SKIP = 4'hB;
  localparam logic [3:0]  OP_INC_SKIP = 4'hF;
  localparam logic [3:0]  OP_RET_LIT  = 4'h4;
  localparam logic [3:0]  OP_PTR_IMM  = 4'h1;
  localparam logic [3:0]  OP_IDXOFS = 4'hF;

  // file addresses of the two indirect access registers share these upper bits
  localparam logic [5:0]  IND_ADDR_HI = 6'h00;

  // pointer update modes carried in the ptr_mode field
  localparam logic [1:0]  PM_PRE_INC  = 2'h0;
  localparam logic [1:0]  PM_PRE_DEC  = 2'h1;
  localparam logic [1:0]  PM_POST_INC = 2'h2;
  localparam logic [1:0]  PM_POST_DEC = 2'h3;

  typedef enum logic [1:0] {
    CLS_BYTE,
    CLS_BIT,
    CLS_LITCTL
  } icdt_class_t;

endpackage : icdt_pkg

// [rtl/icdt_decode.sv]
// combinational classification and field split of one instruction word
`timescale 1ns/100ps
module icdt_decode (
  // instruction word
  input  wire logic [13:0]         word,
  // classification
  output icdt_pkg::icdt_class_t    cls,
  output logic                     flow,
  output logic                     skip,
  output logic                     illegal,
  // operand fields
  output logic [6:0]               file_addr,
  output logic                     dest_file,
  output logic [2:0]               bit_sel,
  output logic [10:0]              literal,
  output logic                     ptr_num,
  output logic [1:0]               ptr_mode,
  // data path needs
  output logic                     refs_indirect_access_register,
  output logic                     needs_rd,
  output logic                     writes_file,
  output logic                     writes_w
);

  logic byte_op;
  logic ptr_mem;

  always_comb begin
    cls         = icdt_pkg::CLS_LITCTL;
    flow        = 1'b0;
    skip        = 1'b0;
    illegal     = 1'b0;
    dest_file   = word[7];
    file_addr   = word[6:0];
    bit_sel     = word[9:7];
    literal     = word[10:0];
    ptr_num     = word[2];
    ptr_mode    = word[1:0];
    needs_rd    = 1'b0;
    writes_file = 1'b0;
    writes_w    = 1'b0;
    byte_op     = 1'b0;
    ptr_mem     = 1'b0;
    unique case (word[13:12])
      icdt_pkg::GRP_BYTE: begin
        if (word[11:7] == 5'h00) begin
          dest_file = 1'b0;
          if (word[6:0] == icdt_pkg::OP_NOP) begin
            flow = 1'b0;
          end else if (word[6:0] == icdt_pkg::OP_RETURN || word[6:0] == icdt_pkg::OP_RET_INT
                       || word[6:0] == icdt_pkg::OP_CALL_WREG
                       || word[6:0] == icdt_pkg::OP_BRANCH_WREG) begin
            flow = 1'b1;
          end else if (word[6:3] == icdt_pkg::OP_MOVIW) begin
            ptr_mem  = 1'b1;
            writes_w = 1'b1;
          end else if (word[6:3] == icdt_pkg::OP_MOVWI) begin
            ptr_mem  = 1'b1;
          end else if (word[6:5] == icdt_pkg::OP_MOVLB) begin
            flow = 1'b0;
          end else begin
            illegal = 1'b1;
          end
        end else begin
          byte_op = 1'b1;
        end
      end
      icdt_pkg::GRP_BIT: begin
        cls         = icdt_pkg::CLS_BIT;
        dest_file   = 1'b1;
        needs_rd    = 1'b1;
        writes_file = ~word[11];
        skip        = word[11];
      end
      icdt_pkg::GRP_FLOW: begin
        flow = 1'b1;
      end
      icdt_pkg::GRP_LIT: begin
        dest_file = 1'b0;
        unique case (word[11:8])
          4'h5, 4'h6, 4'h7, 4'hB, 4'hD: byte_op = 1'b1;
          4'h2, 4'h3:                   flow = 1'b1;
          icdt_pkg::OP_RET_LIT: begin
            flow     = 1'b1;
            writes_w = 1'b1;
          end
          4'h0, 4'h8, 4'h9, 4'hC, 4'hE: writes_w = 1'b1;
          icdt_pkg::OP_PTR_IMM:         ptr_num = word[6];
          icdt_pkg::OP_IDXOFS: begin
            ptr_num  = word[6];
            ptr_mem  = 1'b1;
            writes_w = ~word[7];
          end
          default:                      illegal = 1'b1;
        endcase
      end
    endcase
    if (byte_op) begin
      cls         = icdt_pkg::CLS_BYTE;
      dest_file   = word[7];
      needs_rd    = (word[11:8] != icdt_pkg::OP_MOVWF);
      writes_file = word[7];
      writes_w    = ~word[7];
      skip        = (word[13:12] == icdt_pkg::GRP_BYTE)
                    && (word[11:8] == icdt_pkg::OP_DEC_SKIP
                        || word[11:8] == icdt_pkg::OP_INC_SKIP);
      if (word[13:12] == icdt_pkg::GRP_BYTE && word[11:8] == icdt_pkg::OP_CLR && !word[7]) begin
        file_addr = 7'h00;
        needs_rd  = 1'b0;
      end
    end
    refs_indirect_access_register = ptr_mem;
    // a plain store through the indirect register is an access too
    if ((byte_op || cls == icdt_pkg::CLS_BIT) && file_addr[6:1] == icdt_pkg::IND_ADDR_HI
        && (needs_rd || writes_file)) begin
      refs_indirect_access_register = 1'b1;
      ptr_num   = file_addr[0];
    end
  end

endmodule : icdt_decode

// [rtl/icdt_core.sv]
// instruction fetch, decode and instruction-cycle sequencing
`timescale 1ns/100ps
module icdt_core (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // program memory side
  input  wire logic [13:0]           prog_data,
  output logic                       instr_take,
  // execution side status
  input  wire logic                  cond_true,
  input  wire logic [1:0]            ptr_msb,
  // cycle timing
  output logic [1:0]                 q_phase,
  output logic                       icyc_end,
  output logic                       nop_cycle,
  output logic [1:0]                 instr_cycles,
  // register file strobes
  output logic                       file_rd,
  output logic                       file_wr,
  output logic                       w_wr,
  // decoded instruction
  output icdt_pkg::icdt_class_t      cls,
  output logic [6:0]                 file_addr,
  output logic                       dest_file,
  output logic [2:0]                 bit_sel,
  output logic [10:0]                literal,
  output logic                       ptr_num,
  output logic [1:0]                 ptr_mode,
  output logic                       illegal
);

  typedef enum logic [1:0] {
    ST_EXEC,
    ST_INDIRECT_ACCESS_REGISTER,
    ST_NOP
  } icdt_state_t;

  icdt_state_t           state;
  icdt_state_t           next_state;
  logic [1:0]            next_q_phase;
  logic [1:0]            cyc_cnt;
  logic [1:0]            next_cyc_cnt;
  logic                  flow;
  logic                  skip;
  logic                  refs_indirect_access_register;
  logic                  needs_rd;
  logic                  writes_file;
  logic                  writes_w;
  logic                  load;
  logic                  penalty;
  logic                  data_last;
  logic                  next_instr_take;
  logic                  next_icyc_end;
  logic                  next_nop_cycle;
  logic [1:0]            next_instr_cycles;
  logic                  next_file_rd;
  logic                  next_file_wr;
  logic                  next_w_wr;

  // decoded fields of the word about to be loaded
  icdt_pkg::icdt_class_t d_cls;
  logic                  d_flow;
  logic                  d_skip;
  logic                  d_illegal;
  logic [6:0]            d_file_addr;
  logic                  d_dest_file;
  logic [2:0]            d_bit_sel;
  logic [10:0]           d_literal;
  logic                  d_ptr_num;
  logic [1:0]            d_ptr_mode;
  logic                  d_refs_indirect_access_register;
  logic                  d_needs_rd;
  logic                  d_writes_file;
  logic                  d_writes_w;

  icdt_decode u_decode (
    .word        (prog_data),
    .cls         (d_cls),
    .flow        (d_flow),
    .skip        (d_skip),
    .illegal     (d_illegal),
    .file_addr   (d_file_addr),
    .dest_file   (d_dest_file),
    .bit_sel     (d_bit_sel),
    .literal     (d_literal),
    .ptr_num     (d_ptr_num),
    .ptr_mode    (d_ptr_mode),
    .refs_indirect_access_register   (d_refs_indirect_access_register),
    .needs_rd    (d_needs_rd),
    .writes_file (d_writes_file),
    .writes_w    (d_writes_w)
  );

  // sequencing: the next word is taken on the last edge of the final cycle
  always_comb begin
    next_q_phase = q_phase + 2'h1;
    // top bit of the selected pointer costs one cycle
    penalty      = refs_indirect_access_register && ptr_msb[ptr_num];
    data_last    = (state == ST_INDIRECT_ACCESS_REGISTER) || (state == ST_EXEC && !penalty);
    next_state   = state;
    if (q_phase == icdt_pkg::Q_LAST) begin
      unique case (state)
        ST_EXEC: begin
          if (penalty) begin
            next_state = ST_INDIRECT_ACCESS_REGISTER;
          // second cycle only on flow change or true test
          end else if (flow || (skip && cond_true)) begin
            next_state = ST_NOP;
          end else begin
            next_state = ST_EXEC;
          end
        end
        ST_INDIRECT_ACCESS_REGISTER: next_state = (flow || (skip && cond_true)) ? ST_NOP : ST_EXEC;
        ST_NOP:  next_state = ST_EXEC;
      endcase
    end
    load              = (q_phase == icdt_pkg::Q_LAST) && (next_state == ST_EXEC);
    next_cyc_cnt      = cyc_cnt;
    next_instr_cycles = instr_cycles;
    if (q_phase == icdt_pkg::Q_LAST) begin
      next_cyc_cnt = load ? 2'h0 : cyc_cnt + 2'h1;
      if (load) begin
        next_instr_cycles = cyc_cnt + 2'h1;
      end
    end
    next_instr_take = load;
    next_icyc_end   = (next_q_phase == icdt_pkg::Q_LAST);
    next_nop_cycle  = (next_state == ST_NOP);
    // read early in the first cycle, store at the end of the data cycle
    next_file_rd    = (state == ST_EXEC) && (next_q_phase == icdt_pkg::Q_READ) && needs_rd;
    // result steered by the destination bit
    next_file_wr    = data_last && (next_q_phase == icdt_pkg::Q_LAST) && writes_file;
    next_w_wr       = data_last && (next_q_phase == icdt_pkg::Q_LAST) && writes_w;
    if (next_state != state && q_phase == icdt_pkg::Q_LAST) begin
      next_file_wr = 1'b0;
      next_w_wr    = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state        <= ST_EXEC;
      q_phase      <= icdt_pkg::Q_FIRST;
      cyc_cnt      <= 2'h0;
      instr_cycles <= 2'h1;
      instr_take   <= 1'b0;
      icyc_end     <= 1'b0;
      nop_cycle    <= 1'b0;
      file_rd      <= 1'b0;
      file_wr      <= 1'b0;
      w_wr         <= 1'b0;
    end else begin
      state        <= next_state;
      q_phase      <= next_q_phase;
      cyc_cnt      <= next_cyc_cnt;
      instr_cycles <= next_instr_cycles;
      instr_take   <= next_instr_take;
      icyc_end     <= next_icyc_end;
      nop_cycle    <= next_nop_cycle;
      file_rd      <= next_file_rd;
      file_wr      <= next_file_wr;
      w_wr         <= next_w_wr;
    end
  end

  // instruction register holds the decoded word for its whole life
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cls         <= icdt_pkg::CLS_LITCTL;
      flow        <= 1'b0;
      skip        <= 1'b0;
      illegal     <= 1'b0;
      file_addr   <= 7'h00;
      dest_file   <= 1'b0;
      bit_sel     <= 3'h0;
      literal     <= 11'h000;
      ptr_num     <= 1'b0;
      ptr_mode    <= icdt_pkg::PM_PRE_INC;
      refs_indirect_access_register   <= 1'b0;
      needs_rd    <= 1'b0;
      writes_file <= 1'b0;
      writes_w    <= 1'b0;
    end else if (load) begin
      cls         <= d_cls;
      flow        <= d_flow;
      skip        <= d_skip;
      illegal     <= d_illegal;
      file_addr   <= d_file_addr;
      dest_file   <= d_dest_file;
      bit_sel     <= d_bit_sel;
      literal     <= d_literal;
      ptr_num     <= d_ptr_num;
      ptr_mode    <= d_ptr_mode;
      refs_indirect_access_register   <= d_refs_indirect_access_register;
      // an unlisted word moves no data
      needs_rd    <= d_needs_rd && !d_illegal;
      writes_file <= d_writes_file && !d_illegal;
      writes_w    <= d_writes_w && !d_illegal;
    end
  end

  property p_phase_wrap;
    @(posedge clk_sys) disable iff (rst) q_phase == 2'h3 |=> q_phase == 2'h0;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap) else $error("phase did not wrap");

  property p_end_spacing;
    @(posedge clk_sys) disable iff (rst) icyc_end |=> !icyc_end [*3] ##1 icyc_end;
  endproperty
  a_end_spacing: assert property (p_end_spacing) else $error("cycle end spacing wrong");

  property p_dest;
    @(posedge clk_sys) disable iff (rst) file_wr |-> dest_file && !w_wr && q_phase == 2'h3;
  endproperty
  a_dest: assert property (p_dest) else $error("file store without destination bit");

  property p_flow_nop;
    @(posedge clk_sys) disable iff (rst)
      state == ST_EXEC && q_phase == 2'h3 && flow && !penalty |=> nop_cycle [*4] ##1 !nop_cycle;
  endproperty
  a_flow_nop: assert property (p_flow_nop) else $error("flow change not two cycles");

  property p_skip_false;
    @(posedge clk_sys) disable iff (rst)
      state == ST_EXEC && q_phase == 2'h3 && skip && !cond_true && !penalty |=> instr_take;
  endproperty
  a_skip_false: assert property (p_skip_false) else $error("untaken skip stalled");

  property p_indirect_access_register_pen;
    @(posedge clk_sys) disable iff (rst)
      state == ST_EXEC && q_phase == 2'h3 && refs_indirect_access_register && ptr_msb[ptr_num]
      |=> state == ST_INDIRECT_ACCESS_REGISTER && !instr_take;
  endproperty
  a_indirect_access_register_pen: assert property (p_indirect_access_register_pen) else $error("indirect penalty missing");

  property p_single;
    @(posedge clk_sys) disable iff (rst)
      instr_take && !flow && !skip && !refs_indirect_access_register |-> ##4 instr_take && instr_cycles == 2'h1;
  endproperty
  a_single: assert property (p_single) else $error("plain instruction not one cycle");

  property p_illegal_quiet;
    @(posedge clk_sys) disable iff (rst) illegal |-> !file_wr && !w_wr && !file_rd;
  endproperty
  a_illegal_quiet: assert property (p_illegal_quiet) else $error("unlisted word moved data");

  property p_rd_then_wr;
    @(posedge clk_sys) disable iff (rst) file_wr && state == ST_EXEC && needs_rd |-> $past(file_rd, 2);
  endproperty
  a_rd_then_wr: assert property (p_rd_then_wr) else $error("store without earlier read");

  c_nop: cover property (@(posedge clk_sys) disable iff (rst) $rose(nop_cycle));
  c_indirect_access_register: cover property (@(posedge clk_sys) disable iff (rst) state == ST_INDIRECT_ACCESS_REGISTER);
  c_illegal: cover property (@(posedge clk_sys) disable iff (rst) illegal && instr_take);

endmodule : icdt_core

// [sim/icdt_prog_mem.sv]
// program memory model presenting one instruction word per load
`timescale 1ns/100ps
module icdt_prog_mem (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // core side
  input  wire logic        instr_take,
  input  wire logic [1:0]  q_phase,
  output logic      [13:0] prog_data
);
  logic [13:0] mem [0:63];
  logic [5:0]  addr;

  // whole word
  // the word is only promised in phase 3; elsewhere the inverse shows a mistimed sample
  assign prog_data = (q_phase == 2'h3) ? mem[addr] : ~mem[addr];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr <= 6'h00;
    end else if (instr_take) begin
      addr <= addr + 6'h01;
    end
  end
endmodule : icdt_prog_mem

// [sim/instr_decode_cycle_timing_bench.sv]
// self-checking bench for the instruction decode and cycle timing core
`timescale 1ns/100ps
module instr_decode_cycle_timing_bench;
  localparam int NINS = 60;
  localparam int NDIR = 19;
  logic                  clk_sys;
  logic                  rst;
  logic [13:0]           prog_data;
  logic                  instr_take;
  logic                  cond_true;
  logic [1:0]            ptr_msb;
  logic [1:0]            q_phase;
  logic                  icyc_end;
  logic                  nop_cycle;
  logic [1:0]            instr_cycles;
  logic                  file_rd;
  logic                  file_wr;
  logic                  w_wr;
  icdt_pkg::icdt_class_t cls;
  logic [6:0]            file_addr;
  logic                  dest_file;
  logic [2:0]            bit_sel;
  logic [10:0]           literal;
  logic                  ptr_num;
  logic [1:0]            ptr_mode;
  logic                  illegal;
  int                    err_count;
  int                    checks_done;
  integer                n_clk, n_rd, n_fw, n_ww, n_nop;
  int                    k, i;
  integer                seed;
  logic [13:0]           cur_w;
  logic                  cur_c;
  logic [1:0]            cur_m;
  logic [13:0]           dir_w [0:NDIR-1] = '{14'h0000, 14'h0008, 14'h0009, 14'h000A,
    14'h000B, 14'h3455, 14'h3300, 14'h2123, 14'h2F00, 14'h30FF, 14'h3A5C, 14'h0B80,
    14'h0F01, 14'h1F81, 14'h1000, 14'h0780, 14'h07FF, 14'h077F, 14'h1B00};

  icdt_core icdt_core_inst (.clk_sys(clk_sys), .rst(rst), .prog_data(prog_data),
    .instr_take(instr_take), .cond_true(cond_true), .ptr_msb(ptr_msb), .q_phase(q_phase),
    .icyc_end(icyc_end), .nop_cycle(nop_cycle), .instr_cycles(instr_cycles),
    .file_rd(file_rd), .file_wr(file_wr), .w_wr(w_wr), .cls(cls), .file_addr(file_addr),
    .dest_file(dest_file), .bit_sel(bit_sel), .literal(literal), .ptr_num(ptr_num),
    .ptr_mode(ptr_mode), .illegal(illegal));
  icdt_prog_mem icdt_prog_mem_inst (.clk_sys(clk_sys), .rst(rst), .instr_take(instr_take),
    .q_phase(q_phase), .prog_data(prog_data));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // word touches a file register (random stimulus avoids 00 0000 and 00 0001 forms)
  function automatic logic f_fop(input logic [13:0] w);
    return (w[13:12] == 2'h1) || (w[13:12] == 2'h0 && w[11:8] >= 4'h2);
  endfunction : f_fop

  function automatic logic f_pen(input logic [13:0] w, input logic [1:0] m);
    return f_fop(w) && (w[6:1] == 6'h00) && m[w[0]];
  endfunction : f_pen

  function automatic logic [1:0] exp_cyc(input logic [13:0] w, input logic c,
                                         input logic [1:0] m);
    logic flow;
    logic skp;
    flow = (w[13:12] == 2'h2) || (w[13:9] == 5'h19) || (w[13:8] == 6'h34)
           || (w[13:4] == 10'h000 && w[3:2] == 2'h2);
    skp = (w[13:12] == 2'h1 && w[11]) || (w[13:12] == 2'h0 && w[11:8] inside {4'hB, 4'hF});
    return 2'h1 + {1'b0, f_pen(w, m)} + {1'b0, flow || (skp && c)};
  endfunction : exp_cyc

  function automatic logic [13:0] rand_word();
    logic [31:0] r;
    logic [13:0] w;
    r = $random(seed);
    w = {r[15:14], r[11:0]};
    if (r[15:14] == 2'h0 && r[11:9] == 3'h0) begin
      w[11:8] = 4'h2 | r[11:8];
    end
    if (r[15:14] == 2'h3) begin
      w[13:12] = 2'h1;
    end
    if (r[16]) begin
      w[6:1] = 6'h00;
    end
    return w;
  endfunction : rand_word

  task automatic chk_val(input string name, input logic [10:0] exp, input logic [10:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_val

  task automatic chk_cnt(input string name, input integer exp, input integer got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %0d seen %0d", name, exp, got);
    end
  endtask : chk_cnt

  task automatic close_instr();
    logic [1:0] ec;
    logic       fo;
    ec = exp_cyc(cur_w, cur_c, cur_m);
    fo = f_fop(cur_w);
    chk_cnt("clocks", 4 * ec, n_clk);
    chk_val("instr_cycles", {9'h000, ec}, {9'h000, instr_cycles});
    chk_cnt("nop_clocks", 4 * (ec - 1 - f_pen(cur_w, cur_m)), n_nop);
    chk_cnt("file_rd", fo, n_rd);
    chk_cnt("file_wr", fo && (cur_w[13:12] == 2'h1 ? !cur_w[11] : cur_w[7]), n_fw);
    chk_cnt("w_wr", (fo && cur_w[13:12] == 2'h0 && !cur_w[7]) || (cur_w[13:12] == 2'h3
            && cur_w[11:8] inside {4'h0, 4'h4, 4'h8, 4'h9, 4'hC, 4'hE}), n_ww);
  endtask : close_instr

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (4000) @(posedge clk_sys);
    err_count++;
    wrap_up();
  end

  initial begin
    seed = 32'hB127F897;
    err_count = 0;
    checks_done = 0;
    rst = 1'b1;
    cond_true = 1'b0;
    ptr_msb = 2'h0;
    k = 0;
    {n_clk, n_rd, n_fw, n_ww, n_nop} = '0;
    for (i = 0; i < 64; i++) begin
      icdt_prog_mem_inst.mem[i] = (i < NDIR) ? dir_w[i] : rand_word();
    end
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    while (k < NINS) begin
      @(negedge clk_sys);
      if (instr_take === 1'b1) begin
        if (k > 0) begin
          close_instr();
        end
        cur_w = icdt_prog_mem_inst.mem[k];
        cur_c = $random(seed);
        cur_m = $random(seed);
        cond_true = cur_c;
        ptr_msb = cur_m;
        k++;
        {n_clk, n_rd, n_fw, n_ww, n_nop} = '0;
        chk_val("take_phase", 11'h000, {9'h000, q_phase});
        chk_val("illegal", {10'h000, cur_w[13:8] == 6'h3A}, {10'h000, illegal});
        chk_val("literal", cur_w[10:0], literal);
        chk_val("ptr_mode", {9'h000, cur_w[1:0]}, {9'h000, ptr_mode});
        if (f_fop(cur_w) && cur_w[6:1] == 6'h00) begin
          chk_val("ptr_num", {10'h000, cur_w[0]}, {10'h000, ptr_num});
        end
        if (f_fop(cur_w)) begin
          chk_val("cls", {9'h000, cur_w[13:12] == 2'h1 ? icdt_pkg::CLS_BIT : icdt_pkg::CLS_BYTE},
                  {9'h000, cls});
          chk_val("file_addr", {4'h0, cur_w[6:0]}, {4'h0, file_addr});
        end else if (cur_w[13]) begin
          chk_val("cls", {9'h000, icdt_pkg::CLS_LITCTL}, {9'h000, cls});
        end
        if (f_fop(cur_w) && cur_w[13:12] == 2'h0) begin
          chk_val("dest_file", {10'h000, cur_w[7]}, {10'h000, dest_file});
        end
        if (cur_w[13:12] == 2'h1) begin
          chk_val("bit_sel", {8'h00, cur_w[9:7]}, {8'h00, bit_sel});
        end
      end
      chk_val("icyc_end", {10'h000, q_phase == 2'h3}, {10'h000, icyc_end});
      chk_val("nop_quiet", 11'h000, {10'h000, nop_cycle & (file_rd | file_wr | w_wr)});
      n_clk++;
      n_rd += file_rd;
      n_fw += file_wr;
      n_ww += w_wr;
      n_nop += nop_cycle;
    end
    wrap_up();
  end
endmodule : instr_decode_cycle_timing_bench
